// >>> core/tcirq_cfg.svh
// offsets, bit positions, reset values and event indices of the timer interrupt block
`ifndef TCIRQ_CFG_SVH
`define TCIRQ_CFG_SVH

// register offsets on the byte port
`define TCIRQ_ADR_MASK 5'h00
`define TCIRQ_ADR_FLAGS 5'h01
`define TCIRQ_ADR_XMASK 5'h02
`define TCIRQ_ADR_XFLAGS 5'h03
`define TCIRQ_ADR_CMP_BASE 5'h04
`define TCIRQ_ADR_CAP_BASE 5'h10

// bit positions inside the four mask and flag registers
`define TCIRQ_BIT_CAP 5
`define TCIRQ_BIT_A 4
`define TCIRQ_BIT_B 3
`define TCIRQ_BIT_OVF 2
`define TCIRQ_BIT_T3C 1
`define TCIRQ_BIT_T1C 0

// event indices inside one timer's flag vector
`define TCIRQ_EV_CAP 0
`define TCIRQ_EV_A 1
`define TCIRQ_EV_B 2
`define TCIRQ_EV_C 3
`define TCIRQ_EV_OVF 4

// events that only exist in the extended registers
`define TCIRQ_EXT_T1 5'h08
`define TCIRQ_EXT_T3 5'h1F

// waveform modes that use the capture register as top
`define TCIRQ_TOP_MODE_MASK 4'h9
`define TCIRQ_TOP_MODE_MATCH 4'h8

// reset values
`define TCIRQ_RST_BYTE 8'h00
`define TCIRQ_RST_WORD 16'h0000

`endif

// >>> core/tcirq_pkg.sv
// types shared by the timer interrupt block
package tcirq_pkg;

    // per-timer status coming from the counter logic
    typedef struct packed {
        logic [15:0] counter_value;        // current count
        logic tick;                        // one-cycle timer clock enable
        logic [3:0] waveform_mode_select;  // waveform mode
        logic overflow_evt;                // overflow point of the mode
        logic top_evt;                     // counter reached top
        logic [2:0] forced_strobe;         // forced compare c,b,a
    } tcirq_timer_in_type;

    // byte register port
    typedef struct packed {
        logic [4:0] addr;   // byte address
        logic [7:0] wdata;  // write data
        logic wr;           // write strobe
        logic rd;           // read strobe
    } tcirq_bus_type;

endpackage

// >>> core/tcirq_top.sv
// timer1/timer3 compare, capture and interrupt flag logic
// Overview of operation
// - compare each value to counter every tick
// - high byte held in temp, both at low
// - capture event copies counter; comparator optional
// - capture value usable as counter top
// - low capture read latches high into temp
// - request needs enable, global flag and flag
// - mask: cap 5, a 4, b 3, ovf 2
// - extended mask: t3 5..1, t1 c 0
// - extended registers absent in legacy mode
// - capture flag on event, or top if top
// - flag clears on vector or write one
// - match flag set at following tick
// - forced strobe never sets match flag
// - overflow flag at mode's overflow point
// - flags: cap 5, a 4, b 3, ovf 2
// - extended flags: t3 5..1, t1 c 0
// - capture pin disconnected while capture is top
`timescale 1ns/1ns
`include "tcirq_cfg.svh"

module tcirq_top #(
    parameter int COUNT_WIDTH = 16,
    parameter int CHANNELS = 3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire tcirq_pkg::tcirq_bus_type bus,
    output logic [7:0] bus_rdata,
    input wire tcirq_pkg::tcirq_timer_in_type [1:0] timer_in,
    input wire logic [1:0] capture_input_pin,
    input wire logic [1:0] capture_rising,
    input wire logic acomp_out,
    input wire logic acomp_select,
    input wire logic global_irq_en,
    input wire logic legacy_mode,
    input wire logic [1:0][4:0] vector_done,
    output logic [1:0][4:0] irq_request,
    output logic irq,
    output logic [1:0][2:0] compare_output_pin,
    output logic [1:0][2:0][15:0] compare_value,
    output logic [1:0][15:0] capture_value
);

    // refuse sizes the byte mapping cannot serve
    if (COUNT_WIDTH != 16 || CHANNELS != 3) begin : g_bad_size
        $error("tcirq_top supports only 16-bit counters with three channels");
    end

    logic [1:0][2:0] sync_pipe;      // pin synchronisers, bit 0 first
    logic [1:0] pin_level;           // accepted pin level
    logic [1:0] pin_raw;             // selected capture source
    logic [1:0] cap_edge;            // qualified edge on capture source
    logic [1:0] top_mode;            // capture register serves as top
    logic [1:0] cap_hit;             // capture actually taken
    logic [1:0][2:0] match_now;      // counter equals compare this tick
    logic [1:0][2:0] pend;           // match waiting for next tick
    logic [1:0][4:0] ev_set;         // hardware set terms
    logic [1:0][4:0] w1c;            // software write-one clears
    logic [1:0][4:0] flag;           // sticky event flags
    logic [1:0][4:0] en;             // event enables
    logic [1:0][4:0] ext;            // events of extended registers
    logic [1:0][4:0] next_irq_request;
    logic [7:0] temp;                // shared high byte
    logic [7:0] next_bus_rdata;
    logic chk_wait_a;                // checks only: match a waiting for next tick

    assign ext = {`TCIRQ_EXT_T3, `TCIRQ_EXT_T1};

    // source select; comparator only for timer 1
    always_comb begin
        pin_raw = capture_input_pin;
        if (acomp_select) begin
            pin_raw[0] = acomp_out;
        end
    end

    // three-stage synchroniser on capture sources
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_pipe <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                sync_pipe[t] <= {sync_pipe[t][1:0], pin_raw[t]};
            end
        end
    end

    // level accepted once stages two and three agree
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pin_level <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (sync_pipe[t][1] == sync_pipe[t][2]) begin
                    pin_level[t] <= sync_pipe[t][2];
                end
            end
        end
    end

    // edge, mode decode and match detection
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            cap_edge[t] = (sync_pipe[t][1] == sync_pipe[t][2]) && (sync_pipe[t][2] != pin_level[t])
                && (sync_pipe[t][2] == capture_rising[t]);
            top_mode[t] = (timer_in[t].waveform_mode_select & `TCIRQ_TOP_MODE_MASK)
                == `TCIRQ_TOP_MODE_MATCH;
            cap_hit[t] = cap_edge[t] && !top_mode[t];
            for (int c = 0; c < 3; c++) begin
                match_now[t][c] = timer_in[t].tick
                    && (timer_in[t].counter_value == compare_value[t][c]);
            end
        end
    end

    // match remembered until the next timer clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (timer_in[t].tick) begin
                    pend[t] <= match_now[t];
                end
            end
        end
    end

    // waveform match pulse, forced strobe included
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            compare_output_pin <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                compare_output_pin[t] <= match_now[t] | timer_in[t].forced_strobe;
            end
        end
    end

    // hardware set terms per event
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            ev_set[t][`TCIRQ_EV_CAP] = top_mode[t] ? timer_in[t].top_evt : cap_hit[t];
            for (int c = 0; c < 3; c++) begin
                ev_set[t][`TCIRQ_EV_A + c] = timer_in[t].tick && pend[t][c];
            end
            ev_set[t][`TCIRQ_EV_OVF] = timer_in[t].overflow_evt;
        end
    end

    // write-one clears decoded from the flag registers
    always_comb begin
        w1c = '0;
        if (bus.wr && bus.addr == `TCIRQ_ADR_FLAGS) begin
            w1c[0][`TCIRQ_EV_CAP] = bus.wdata[`TCIRQ_BIT_CAP];
            w1c[0][`TCIRQ_EV_A] = bus.wdata[`TCIRQ_BIT_A];
            w1c[0][`TCIRQ_EV_B] = bus.wdata[`TCIRQ_BIT_B];
            w1c[0][`TCIRQ_EV_OVF] = bus.wdata[`TCIRQ_BIT_OVF];
        end
        if (bus.wr && bus.addr == `TCIRQ_ADR_XFLAGS && !legacy_mode) begin
            w1c[1][`TCIRQ_EV_CAP] = bus.wdata[`TCIRQ_BIT_CAP];
            w1c[1][`TCIRQ_EV_A] = bus.wdata[`TCIRQ_BIT_A];
            w1c[1][`TCIRQ_EV_B] = bus.wdata[`TCIRQ_BIT_B];
            w1c[1][`TCIRQ_EV_OVF] = bus.wdata[`TCIRQ_BIT_OVF];
            w1c[1][`TCIRQ_EV_C] = bus.wdata[`TCIRQ_BIT_T3C];
            w1c[0][`TCIRQ_EV_C] = bus.wdata[`TCIRQ_BIT_T1C];
        end
    end

    // sticky flags; a set beats any clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flag <= '0;
        end else begin
            flag <= ev_set | (flag & ~(w1c | vector_done));
        end
    end

    // enable registers; reserved bits 7:6 are dropped
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            en <= '0;
        end else begin
            if (bus.wr && bus.addr == `TCIRQ_ADR_MASK) begin
                en[0][`TCIRQ_EV_CAP] <= bus.wdata[`TCIRQ_BIT_CAP];
                en[0][`TCIRQ_EV_A] <= bus.wdata[`TCIRQ_BIT_A];
                en[0][`TCIRQ_EV_B] <= bus.wdata[`TCIRQ_BIT_B];
                en[0][`TCIRQ_EV_OVF] <= bus.wdata[`TCIRQ_BIT_OVF];
            end
            if (bus.wr && bus.addr == `TCIRQ_ADR_XMASK && !legacy_mode) begin
                en[1][`TCIRQ_EV_CAP] <= bus.wdata[`TCIRQ_BIT_CAP];
                en[1][`TCIRQ_EV_A] <= bus.wdata[`TCIRQ_BIT_A];
                en[1][`TCIRQ_EV_B] <= bus.wdata[`TCIRQ_BIT_B];
                en[1][`TCIRQ_EV_OVF] <= bus.wdata[`TCIRQ_BIT_OVF];
                en[1][`TCIRQ_EV_C] <= bus.wdata[`TCIRQ_BIT_T3C];
                en[0][`TCIRQ_EV_C] <= bus.wdata[`TCIRQ_BIT_T1C];
            end
        end
    end

    // vector request: enable, global flag and event flag together
    always_comb begin
        for (int t = 0; t < 2; t++) begin
            next_irq_request[t] = flag[t] & en[t] & {5{global_irq_en}}
                & ~(ext[t] & {5{legacy_mode}});
        end
    end

    // registered requests and summary level
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_request <= '0;
            irq <= 1'b0;
        end else begin
            irq_request <= next_irq_request;
            irq <= |next_irq_request;
        end
    end

    // shared high byte: loaded by high writes and low capture reads
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            temp <= `TCIRQ_RST_BYTE;
        end else begin
            for (int t = 0; t < 2; t++) begin
                for (int c = 0; c < 3; c++) begin
                    if (bus.wr && bus.addr == 5'(`TCIRQ_ADR_CMP_BASE + 2 * (3 * t + c) + 1)) begin
                        temp <= bus.wdata;
                    end
                end
                if (bus.wr && bus.addr == 5'(`TCIRQ_ADR_CAP_BASE + 2 * t + 1)) begin
                    temp <= bus.wdata;
                end
                if (bus.rd && bus.addr == 5'(`TCIRQ_ADR_CAP_BASE + 2 * t)) begin
                    temp <= capture_value[t][15:8];
                end
            end
        end
    end

    // compare values take both bytes at the low-byte write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            compare_value <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                for (int c = 0; c < 3; c++) begin
                    if (bus.wr && bus.addr == 5'(`TCIRQ_ADR_CMP_BASE + 2 * (3 * t + c))) begin
                        compare_value[t][c] <= {temp, bus.wdata};
                    end
                end
            end
        end
    end

    // capture values: pin event first, software write otherwise
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            capture_value <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (cap_hit[t]) begin
                    capture_value[t] <= timer_in[t].counter_value;
                end else if (bus.wr && bus.addr == 5'(`TCIRQ_ADR_CAP_BASE + 2 * t)) begin
                    capture_value[t] <= {temp, bus.wdata};
                end
            end
        end
    end

    // read multiplexer; unmapped and absent registers read zero
    always_comb begin
        next_bus_rdata = `TCIRQ_RST_BYTE;
        if (bus.addr == `TCIRQ_ADR_MASK) begin
            next_bus_rdata = {2'h0, en[0][`TCIRQ_EV_CAP], en[0][`TCIRQ_EV_A], en[0][`TCIRQ_EV_B],
                en[0][`TCIRQ_EV_OVF], 2'h0};
        end else if (bus.addr == `TCIRQ_ADR_FLAGS) begin
            next_bus_rdata = {2'h0, flag[0][`TCIRQ_EV_CAP], flag[0][`TCIRQ_EV_A], flag[0][`TCIRQ_EV_B],
                flag[0][`TCIRQ_EV_OVF], 2'h0};
        end else if (bus.addr == `TCIRQ_ADR_XMASK && !legacy_mode) begin
            next_bus_rdata = {2'h0, en[1][`TCIRQ_EV_CAP], en[1][`TCIRQ_EV_A], en[1][`TCIRQ_EV_B],
                en[1][`TCIRQ_EV_OVF], en[1][`TCIRQ_EV_C], en[0][`TCIRQ_EV_C]};
        end else if (bus.addr == `TCIRQ_ADR_XFLAGS && !legacy_mode) begin
            next_bus_rdata = {2'h0, flag[1][`TCIRQ_EV_CAP], flag[1][`TCIRQ_EV_A], flag[1][`TCIRQ_EV_B],
                flag[1][`TCIRQ_EV_OVF], flag[1][`TCIRQ_EV_C], flag[0][`TCIRQ_EV_C]};
        end
        for (int t = 0; t < 2; t++) begin
            for (int c = 0; c < 3; c++) begin
                if (bus.addr == 5'(`TCIRQ_ADR_CMP_BASE + 2 * (3 * t + c))) begin
                    next_bus_rdata = compare_value[t][c][7:0];
                end
                if (bus.addr == 5'(`TCIRQ_ADR_CMP_BASE + 2 * (3 * t + c) + 1)) begin
                    next_bus_rdata = compare_value[t][c][15:8];
                end
            end
            if (bus.addr == 5'(`TCIRQ_ADR_CAP_BASE + 2 * t)) begin
                next_bus_rdata = capture_value[t][7:0];
            end
            if (bus.addr == 5'(`TCIRQ_ADR_CAP_BASE + 2 * t + 1)) begin
                next_bus_rdata = temp;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= `TCIRQ_RST_BYTE;
        end else begin
            bus_rdata <= bus.rd ? next_bus_rdata : `TCIRQ_RST_BYTE;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // checks only: remembers an equal count at a tick until the next tick
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            chk_wait_a <= 1'b0;
        end else if (timer_in[0].tick) begin
            chk_wait_a <= timer_in[0].counter_value == compare_value[0][0];
        end
    end

    // the tick that follows a match tick
    sequence s_match_then_tick;
        chk_wait_a && timer_in[0].tick;
    endsequence
    property p_match_flag;
        s_match_then_tick |=> flag[0][`TCIRQ_EV_A];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not set at next tick");
    property p_no_forced_flag;
        $rose(flag[0][`TCIRQ_EV_A]) |-> $past(pend[0][0] && timer_in[0].tick);
    endproperty
    a_no_forced_flag: assert property (p_no_forced_flag) else $error("match flag set without match");
    property p_request;
        (flag[1][`TCIRQ_EV_C] && en[1][`TCIRQ_EV_C] && global_irq_en && !legacy_mode)
            |=> irq_request[1][`TCIRQ_EV_C] && irq;
    endproperty
    a_request: assert property (p_request) else $error("enabled flag gave no request");
    property p_no_request;
        !global_irq_en |=> irq_request == '0 && !irq;
    endproperty
    a_no_request: assert property (p_no_request) else $error("request without global enable");
    property p_set_wins;
        (ev_set[0][`TCIRQ_EV_OVF] && (w1c[0][`TCIRQ_EV_OVF] || vector_done[0][`TCIRQ_EV_OVF]))
            |=> flag[0][`TCIRQ_EV_OVF];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");
    property p_clear;
        (w1c[1][`TCIRQ_EV_C] && !ev_set[1][`TCIRQ_EV_C]) |=> !flag[1][`TCIRQ_EV_C];
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear flag");
    property p_capture;
        cap_hit[0] |=> capture_value[0] == $past(timer_in[0].counter_value);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value not taken");
    property p_pin_off_in_top;
        top_mode[0] |=> capture_value[0] == $past(capture_value[0]) || $past(bus.wr);
    endproperty
    a_pin_off_in_top: assert property (p_pin_off_in_top) else $error("capture while top");
    property p_legacy_read;
        (bus.rd && legacy_mode && bus.addr == `TCIRQ_ADR_XMASK) |=> bus_rdata == 8'h00;
    endproperty
    a_legacy_read: assert property (p_legacy_read) else $error("extended mask visible in legacy");
    property p_cmp_write;
        (bus.wr && bus.addr == `TCIRQ_ADR_CMP_BASE) |=> compare_value[0][0] == {$past(temp), $past(bus.wdata)};
    endproperty
    a_cmp_write: assert property (p_cmp_write) else $error("compare write not paired");
    property p_cap_read;
        (bus.rd && bus.addr == `TCIRQ_ADR_CAP_BASE && !bus.wr) |=> temp == $past(capture_value[0][15:8]);
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("high byte not latched");

endmodule

// >>> verification/tb.sv
// self-checking bench for the timer compare, capture and interrupt block
`timescale 1ns/1ns

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module tb;
    typedef struct {logic [4:0] a; logic [7:0] d; logic [7:0] e;} tcirq_row_type;

    logic clock, rstn; // clock and active-low reset
    tcirq_pkg::tcirq_bus_type bus; // register port
    logic [7:0] bus_rdata, d; // read data and last value read
    logic [4:0] a; // scratch address
    wire tcirq_pkg::tcirq_timer_in_type [1:0] timer_in; // counter status
    logic [1:0] capture_input_pin, capture_rising, step, load;
    logic acomp_out, acomp_select, global_irq_en, legacy_mode, irq;
    logic [1:0][4:0] vector_done, irq_request;
    logic [1:0][2:0] compare_output_pin, pin_seen, force_strobe;
    logic [1:0][2:0][15:0] compare_value;
    logic [1:0][15:0] capture_value, load_value;
    logic [1:0][3:0] mode;
    int miscompares, check_count;
    // register rows: address, written value, value read back
    tcirq_row_type rows[5] = '{'{5'h00, 8'hFF, 8'h3C}, '{5'h02, 8'h3F, 8'h3F}, '{5'h1F, 8'hFF, 8'h00},
        '{5'h01, 8'h00, 8'h00}, '{5'h03, 8'h00, 8'h00}};

    // 50 ns clock
    always #25 clock = ~clock;

    // remembers every compare pin pulse until the bench clears it
    always @(posedge clock) pin_seen <= pin_seen | compare_output_pin;

    tcirq_top u_dut (.clock(clock), .rstn(rstn), .bus(bus), .bus_rdata(bus_rdata), .timer_in(timer_in),
        .capture_input_pin(capture_input_pin), .capture_rising(capture_rising), .acomp_out(acomp_out),
        .acomp_select(acomp_select), .global_irq_en(global_irq_en), .legacy_mode(legacy_mode),
        .vector_done(vector_done), .irq_request(irq_request), .irq(irq),
        .compare_output_pin(compare_output_pin), .compare_value(compare_value), .capture_value(capture_value));

    // one counter model per timer, top taken from the capture register
    for (genvar t = 0; t < 2; t++) begin : g_cnt
        tcirq_counter_model u_cnt (.clock(clock), .rstn(rstn), .step(step[t]), .load(load[t]),
            .load_value(load_value[t]), .mode(mode[t]), .force_strobe(force_strobe[t]),
            .top_value(capture_value[t]), .status(timer_in[t]));
    end

    // one-cycle write strobe
    task automatic wr(input logic [4:0] ad, input logic [7:0] dt);
        @(posedge clock);
        bus <= '{ad, dt, 1'b1, 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
        #1;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [4:0] ad, output logic [7:0] dt);
        @(posedge clock);
        bus <= '{ad, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 dt = bus_rdata;
    endtask

    // one timer clock tick
    task automatic step_timer(input int t);
        @(posedge clock);
        step[t] <= 1'b1;
        @(posedge clock);
        step[t] <= 1'b0;
        #1;
    endtask

    // preset a counter
    task automatic load_timer(input int t, input logic [15:0] v);
        @(posedge clock);
        load[t] <= 1'b1;
        load_value[t] <= v;
        @(posedge clock);
        load[t] <= 1'b0;
    endtask

    task automatic wait_cy(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        finish_test();
    end

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        bus = '0;
        {capture_input_pin, capture_rising, step, load} = '0;
        {acomp_out, acomp_select, global_irq_en, legacy_mode} = '0;
        vector_done = '0;
        force_strobe = '0;
        load_value = '0;
        mode = '0;
        pin_seen = '0;
        miscompares = 0;
        check_count = 0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        // reset values of the four mask and flag registers
        for (int i = 0; i < 4; i++) begin
            rd(5'(i), d);
            `CHK("reset reg", 8'h00, d);
        end
        `CHK("irq at reset", 1'b0, irq);
        $display("done: reset");
        // ordinary rows: masks, flags, unmapped place
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, d);
            `CHK("reg row", rows[i].e, d);
        end
        $display("done: registers");
        // compare words: high byte waits in temp until the low byte
        for (int i = 0; i < 6; i++) begin
            a = 5'h04 + 5'(2 * i);
            wr(a + 5'h01, 8'(8'h11 * (i + 1)));
            `CHK("cmp before low", 16'h0000, compare_value[i / 3][i % 3]);
            wr(a, 8'hA0 + 8'(i));
            `CHK("cmp word", {8'(8'h11 * (i + 1)), 8'hA0 + 8'(i)}, compare_value[i / 3][i % 3]);
            rd(a + 5'h01, d);
            `CHK("cmp high", 8'(8'h11 * (i + 1)), d);
        end
        $display("done: compare words");
        // match flag only at the tick after the equal tick
        load_timer(0, 16'h11A0);
        step_timer(0);
        rd(5'h01, d);
        `CHK("flag at match tick", 8'h00, d);
        step_timer(0);
        rd(5'h01, d);
        `CHK("match a flag", 8'h10, d);
        `CHK("match pin", 1'b1, pin_seen[0][0]);
        `CHK("req without global", 1'b0, irq_request[0][1]);
        @(posedge clock);
        global_irq_en <= 1'b1;
        wait_cy(2);
        `CHK("req match a", 1'b1, irq_request[0][1]);
        `CHK("irq", 1'b1, irq);
        @(posedge clock);
        vector_done[0][1] <= 1'b1;
        @(posedge clock);
        vector_done[0][1] <= 1'b0;
        rd(5'h01, d);
        `CHK("vector clear", 8'h00, d);
        wait_cy(1);
        `CHK("irq after clear", 1'b0, irq);
        $display("done: match and vector");
        // forced strobe drives the pin but leaves flags alone
        pin_seen = '0;
        @(posedge clock);
        force_strobe[0][1] <= 1'b1;
        @(posedge clock);
        force_strobe[0][1] <= 1'b0;
        rd(5'h01, d);
        `CHK("forced no flag", 8'h00, d);
        `CHK("forced pin", 1'b1, pin_seen[0][1]);
        // overflow flag, then write-one clear
        load_timer(0, 16'hFFFF);
        step_timer(0);
        rd(5'h01, d);
        `CHK("overflow flag", 8'h04, d);
        wr(5'h01, 8'h04);
        rd(5'h01, d);
        `CHK("w1c overflow", 8'h00, d);
        // overflow tick and write-one clear in one cycle
        load_timer(0, 16'hFFFF);
        fork
            step_timer(0);
            wr(5'h01, 8'h04);
        join
        rd(5'h01, d);
        `CHK("set beats clear", 8'h04, d);
        wr(5'h01, 8'h04);
        $display("done: forced and overflow");
        // rising capture, low read latches high, falling capture meanwhile
        load_timer(0, 16'h1357);
        @(posedge clock);
        capture_rising[0] <= 1'b1;
        capture_input_pin[0] <= 1'b1;
        wait_cy(8);
        `CHK("capture word", 16'h1357, capture_value[0]);
        rd(5'h01, d);
        `CHK("capture flag", 8'h20, d);
        rd(5'h10, d);
        `CHK("capture low", 8'h57, d);
        load_timer(0, 16'h2468);
        @(posedge clock);
        capture_rising[0] <= 1'b0;
        capture_input_pin[0] <= 1'b0;
        wait_cy(8);
        `CHK("falling capture", 16'h2468, capture_value[0]);
        rd(5'h11, d);
        `CHK("capture high kept", 8'h13, d);
        wr(5'h01, 8'h20);
        rd(5'h01, d);
        `CHK("w1c capture", 8'h00, d);
        $display("done: capture");
        // capture as top: pin ignored, flag from reaching top
        @(posedge clock);
        mode[0] <= 4'hC;
        capture_rising[0] <= 1'b1;
        capture_input_pin[0] <= 1'b1;
        wait_cy(8);
        `CHK("pin ignored", 16'h2468, capture_value[0]);
        rd(5'h01, d);
        `CHK("no flag from pin", 8'h00, d);
        load_timer(0, 16'h2467);
        step_timer(0);
        step_timer(0);
        rd(5'h01, d);
        `CHK("top flag", 8'h20, d);
        wr(5'h01, 8'h20);
        $display("done: capture top");
        // timer 3 channel c in the extended registers, hidden in legacy mode
        load_timer(1, 16'h66A5);
        step_timer(1);
        step_timer(1);
        rd(5'h03, d);
        `CHK("ext flag t3 c", 8'h02, d);
        `CHK("ext req t3 c", 1'b1, irq_request[1][3]);
        @(posedge clock);
        legacy_mode <= 1'b1;
        rd(5'h03, d);
        `CHK("legacy ext flags", 8'h00, d);
        rd(5'h02, d);
        `CHK("legacy ext mask", 8'h00, d);
        wait_cy(1);
        `CHK("legacy no req", 1'b0, irq_request[1][3]);
        @(posedge clock);
        legacy_mode <= 1'b0;
        wr(5'h03, 8'h02);
        rd(5'h03, d);
        `CHK("w1c ext", 8'h00, d);
        $display("done: extended");
        // comparator as timer 1 capture source
        load_timer(0, 16'h0ACE);
        @(posedge clock);
        mode[0] <= 4'h0;
        acomp_select <= 1'b1;
        wait_cy(8);
        `CHK("falling source kept", 16'h2468, capture_value[0]);
        @(posedge clock);
        acomp_out <= 1'b1;
        wait_cy(8);
        `CHK("comparator capture", 16'h0ACE, capture_value[0]);
        $display("done: comparator");
        finish_test();
    end
endmodule

// >>> verification/tcirq_counter_model.sv
// counter-side model that feeds one timer's status into the interrupt block
`timescale 1ns/1ns

module tcirq_counter_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic step,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic [3:0] mode,
    input wire logic [2:0] force_strobe,
    input wire logic [15:0] top_value,
    output tcirq_pkg::tcirq_timer_in_type status
);
    logic [15:0] count; // running count
    logic top_hit; // count sits at top in a capture-top mode

    // capture-top modes are 8, 10, 12 and 14
    assign top_hit = ((mode & 4'h9) == 4'h8) && (count == top_value);

    // status seen by the block; tick lasts one cycle per step
    always_comb begin
        status = '0;
        status.counter_value = count;
        status.tick = step;
        status.waveform_mode_select = mode;
        status.overflow_evt = step && (count == 16'hFFFF); // wrap point of normal mode
        status.top_evt = step && top_hit; // top reached
        status.forced_strobe = force_strobe;
    end

    // count up per tick, wrap at top; a load overrides the count
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 16'h0000;
        end else if (load) begin
            count <= load_value;
        end else if (step) begin
            count <= top_hit ? 16'h0000 : count + 16'h0001;
        end
    end
endmodule
